// ---- hdl/pwmpe_channel.sv ----
// Purpose: One PWM output channel: set on match, reset on counter clear
// Assumes: Match is qualified by the counter tick; clear is a wrap match on a tick or a software clear write
// Notes: Output level is the raw state, before polarity and gating
`timescale 1ns/10ps
`default_nettype none
module pwmpe_channel (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_match,
  input wire logic i_clear,
  output logic o_state
);
  logic st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (i_clear) begin
      st_d = 1'b0;
    end else if (i_match) begin
      st_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_state = st_q;
endmodule
`default_nettype wire

// ---- hdl/pwmpe_pkg.sv ----
// Purpose: Shared constants and types for the PWM generator block
// Assumes: Register port with one-cycle-late read data
// Notes: Offsets are byte indices on an 8-bit register port
package pwmpe_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CHAN_N = 8;
  localparam logic [7:0] ADDR_MATCH0 = 8'hf0;
  localparam logic [7:0] ADDR_WRAP = 8'hf8;
  localparam logic [7:0] ADDR_COUNT = 8'hf9;
  localparam logic [7:0] ADDR_CTRL = 8'hfa;
  localparam logic [7:0] ADDR_POL = 8'hfb;
  localparam logic [7:0] ADDR_GATE = 8'hfc;
  localparam logic [7:0] CTRL_RESET = 8'h0c;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] WRAP_RESET = 8'hff;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [1:0] CTRL_RSVD_ONES = 2'h3;
  localparam int CTRL_DIV_HI = 7;
  localparam int CTRL_DIV_LO = 4;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pwmpe_req_t;

  typedef struct packed {
    logic [3:0] divider_setting;
    logic counter_enable;
  } pwmpe_ctrl_t;
endpackage

// ---- hdl/pwmpe_prescaler.sv ----
// Purpose: Reloadable 4-bit down-counting prescaler giving counter ticks
// Assumes: Same clock as the register file
// Notes: Tick rate is core clock over 2*(setting+1)
`timescale 1ns/10ps
`default_nettype none
module pwmpe_prescaler (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic i_reload,
  input wire logic [3:0] i_setting,
  output logic o_tick
);
  logic [3:0] cnt_q, cnt_d;
  logic half_q, half_d;

  always_comb begin
    cnt_d = cnt_q;
    half_d = half_q;
    o_tick = 1'b0;
    if (i_reload) begin
      cnt_d = i_setting;
      half_d = 1'b0;
    end else if (i_run) begin
      half_d = ~half_q; // Fixed divide by 2 ahead of the prescaler
      if (half_q) begin
        if (cnt_q == 4'h0) begin
          cnt_d = i_setting;
          o_tick = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= 4'h0;
      half_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      half_q <= half_d;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/pwmpe_top.sv ----
// Purpose: Eight-channel PWM generator with prescaler, polarity and gating
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes: Registers reached over a plain strobe port, read data one cycle late
// Functional notes
// - Divider setting reloads prescaler at zero
// - Tick rate is clock over 2*(setting+1)
// - Control register resets to 0Ch
// - Reserved control bits 3:2 read one
// - Clear zeroes counter, reloads prescaler, clears channel states
// - Enable runs counter; disable holds values
// - Non-inverted match drives output high
// - Every counter clear drives non-inverted outputs low where gate bit is one
// - Invert bit swaps match and clear levels
// - Gate bit zero forces output high
// - Gate bit one passes channel waveform
// - Counter counts up, resets zero, readable
// - Wrap value match clears counter, reset FFh
// - Eight compare values, reset zero
`timescale 1ns/10ps
`default_nettype none
module pwmpe_top #(
  parameter int CHANNELS = pwmpe_pkg::CHAN_N
) (
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic [CHANNELS-1:0] O_PWM
);
  pwmpe_pkg::pwmpe_req_t req;
  pwmpe_pkg::pwmpe_ctrl_t ctrl_q, ctrl_d;
  logic [7:0] pol_q, pol_d;
  logic [7:0] gate_q, gate_d;
  logic [7:0] wrap_q, wrap_d;
  logic [7:0] match_q [CHANNELS];
  logic [7:0] match_d [CHANNELS];
  logic [7:0] count_q, count_d;
  logic [7:0] rdata_q, rdata_d;
  logic [CHANNELS-1:0] pwm_q, pwm_d;
  logic [CHANNELS-1:0] state;
  logic sw_clear;
  logic tick;
  logic wrap_hit;
  logic cnt_clear;

  assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

  // Clear is a write-only pulse, never stored
  assign sw_clear = req.wr && (req.addr == pwmpe_pkg::ADDR_CTRL) &&
                    req.wdata[pwmpe_pkg::CTRL_CLR_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    pol_d = pol_q;
    gate_d = gate_q;
    wrap_d = wrap_q;
    for (int i = 0; i < CHANNELS; i++) begin
      match_d[i] = match_q[i];
    end
    if (req.wr) begin
      case (req.addr)
        pwmpe_pkg::ADDR_CTRL: begin
          ctrl_d.divider_setting =
            req.wdata[pwmpe_pkg::CTRL_DIV_HI:pwmpe_pkg::CTRL_DIV_LO];
          ctrl_d.counter_enable = req.wdata[pwmpe_pkg::CTRL_EN_BIT];
        end
        pwmpe_pkg::ADDR_POL: pol_d = req.wdata;
        pwmpe_pkg::ADDR_GATE: gate_d = req.wdata;
        pwmpe_pkg::ADDR_WRAP: wrap_d = req.wdata;
        default: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (req.addr == pwmpe_pkg::ADDR_MATCH0 + 8'(i)) begin
              match_d[i] = req.wdata;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      ctrl_q.divider_setting <=
        pwmpe_pkg::CTRL_RESET[pwmpe_pkg::CTRL_DIV_HI:pwmpe_pkg::CTRL_DIV_LO];
      ctrl_q.counter_enable <=
        pwmpe_pkg::CTRL_RESET[pwmpe_pkg::CTRL_EN_BIT];
      pol_q <= pwmpe_pkg::POL_RESET;
      gate_q <= pwmpe_pkg::GATE_RESET;
      wrap_q <= pwmpe_pkg::WRAP_RESET;
      for (int i = 0; i < CHANNELS; i++) begin
        match_q[i] <= pwmpe_pkg::MATCH_RESET;
      end
    end else begin
      ctrl_q <= ctrl_d;
      pol_q <= pol_d;
      gate_q <= gate_d;
      wrap_q <= wrap_d;
      for (int i = 0; i < CHANNELS; i++) begin
        match_q[i] <= match_d[i];
      end
    end
  end

  // New divider takes effect from the write cycle onward
  pwmpe_prescaler u_presc (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_run(ctrl_q.counter_enable),
    .i_reload(sw_clear),
    .i_setting(ctrl_d.divider_setting),
    .o_tick(tick)
  );

  // Wrap match clears on a tick; free-running overflow only rolls the count over
  assign wrap_hit = tick && (count_q == wrap_q);
  assign cnt_clear = sw_clear || wrap_hit;

  always_comb begin
    count_d = count_q;
    if (sw_clear) begin
      count_d = pwmpe_pkg::COUNT_RESET;
    end else if (tick) begin
      if (wrap_hit) begin
        count_d = pwmpe_pkg::COUNT_RESET;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      count_q <= pwmpe_pkg::COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      pwmpe_channel u_chan (
        .i_clk(I_REF_CLK),
        .i_srst(I_SRST),
        .i_match(tick && (count_q == match_q[g])),
        .i_clear(cnt_clear),
        .o_state(state[g])
      );
      always_comb begin
        if (!gate_q[g]) begin
          pwm_d[g] = 1'b1;
        end else begin
          pwm_d[g] = state[g] ^ pol_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      pwm_q <= '1;
    end else begin
      pwm_q <= pwm_d;
    end
  end

  assign O_PWM = pwm_q;

  always_comb begin
    rdata_d = pwmpe_pkg::UNMAPPED_READ;
    if (req.rd) begin
      case (req.addr)
        pwmpe_pkg::ADDR_CTRL:
          rdata_d = {ctrl_q.divider_setting, pwmpe_pkg::CTRL_RSVD_ONES,
                     1'b0, ctrl_q.counter_enable};
        pwmpe_pkg::ADDR_POL: rdata_d = pol_q;
        pwmpe_pkg::ADDR_GATE: rdata_d = gate_q;
        pwmpe_pkg::ADDR_WRAP: rdata_d = wrap_q;
        pwmpe_pkg::ADDR_COUNT: rdata_d = count_q;
        default: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (req.addr == pwmpe_pkg::ADDR_MATCH0 + 8'(i)) begin
              rdata_d = match_q[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      rdata_q <= pwmpe_pkg::UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;
endmodule
`default_nettype wire

// ---- tb/pwmpe_pin_load.sv ----
// Purpose: Pin load model counting high cycles on each output pin
// Assumes: Pins sampled on the core clock
// Notes: Counts restart while i_clr is high
`timescale 1ns/10ps
`default_nettype none
module pwmpe_pin_load (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic [7:0] i_pin,
  output logic [7:0] o_hi [8]
);
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 8; k++) begin
      o_hi[k] <= i_clr ? 8'h00 : o_hi[k] + {7'h00, i_pin[k]};
    end
  end
endmodule
`default_nettype wire

// ---- tb/pwmpe_props.sv ----
// Purpose: Port checker for the PWM generator
// Assumes: Read data stands one cycle after the read strobe
// Notes: Shadows gate, polarity and enable bits from writes
`timescale 1ns/10ps
`default_nettype none
module pwmpe_props #(
  parameter int CHANNELS = 8
) (
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic [CHANNELS-1:0] O_PWM
);
  logic [7:0] gate_q, gate_d, pol_q, pol_d;
  logic en_q, en_d;
  logic [2:0] wq_q, wq_d;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  always_comb begin
    gate_d = gate_q;
    pol_d = pol_q;
    en_d = en_q;
    wq_d = wq_q + {2'h0, wq_q != 3'h7};
    if (I_WR) begin
      wq_d = 3'h0;
      case (I_ADDR)
        8'hfa: en_d = I_WDATA[0];
        8'hfb: pol_d = I_WDATA;
        8'hfc: gate_d = I_WDATA;
        default: ;
      endcase
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      {gate_q, pol_q, en_q, wq_q} <= '0;
    end else begin
      {gate_q, pol_q, en_q, wq_q} <= {gate_d, pol_d, en_d, wq_d};
    end
  end
  sequence s_clr_wr;
    I_WR && I_ADDR == 8'hfa && I_WDATA[1:0] == 2'h2;
  endsequence
  sequence s_cnt_rd;
    I_RD && I_ADDR == 8'hf9;
  endsequence
  sequence s_ctrl_rd;
    I_RD && I_ADDR == 8'hfa;
  endsequence
  a_gate_reset: assert property ($fell(I_SRST) |-> &O_PWM)
    else $error("outputs not high after reset");
  a_gate_force: assert property (
    (~gate_q[CHANNELS-1:0] & ~$past(gate_q[CHANNELS-1:0]) & ~O_PWM) == '0)
    else $error("gated output not forced high");
  a_rsvd_ones: assert property (
    s_ctrl_rd |=> O_RDATA[3:2] == 2'h3)
    else $error("reserved control bits not one");
  a_clr_reads0: assert property (s_ctrl_rd |=> !O_RDATA[1])
    else $error("clear bit read back as one");
  a_clear_count: assert property (
    s_clr_wr ##2 s_cnt_rd |=> O_RDATA == 8'h00)
    else $error("count not zero after clear");
  a_halt_hold: assert property (
    !en_q && wq_q > 3'h3 |-> $stable(O_PWM))
    else $error("output moved while halted");
  a_tick_once: assert property (
    wq_q > 3'h3 && $changed(O_PWM) |=> $stable(O_PWM))
    else $error("output changed twice within one tick");
  a_pol_flip: assert property (
    I_WR && I_ADDR == 8'hfb && I_WDATA == ~pol_q && !en_q && wq_q > 3'h3
    |-> ##2 (O_PWM ^ $past(O_PWM, 2)) == gate_q[CHANNELS-1:0])
    else $error("inversion did not flip enabled outputs");
endmodule
bind pwmpe_top pwmpe_props #(.CHANNELS(CHANNELS)) pwmpe_props_i (
  .I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_PWM(O_PWM));
`default_nettype wire

// ---- tb/pwmpe_tb_top.sv ----
// Purpose: Register and waveform tests for the PWM generator
// Assumes: Inputs driven by non-blocking assignment after rising edges
// Notes: Duty cycles are read from the pin load model over 64 clocks
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pwmpe_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clr = 1'b1;
  logic [7:0] rdata, pwm, v, c0;
  logic [7:0] hi [8];
  logic [7:0] ra [7] = '{8'hfa, 8'hfb, 8'hfc, 8'hf8, 8'hf0, 8'hf7, 8'hf9};
  logic [7:0] re [7] = '{8'h0c, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [3:0] sv [2] = '{4'h0, 4'hf};
  int n_fail = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  pwmpe_top pwmpe_top_i (.I_REF_CLK(clk), .I_SRST(srst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_PWM(pwm));
  pwmpe_pin_load pwmpe_pin_load_i (.i_clk(clk), .i_clr(clr), .i_pin(pwm),
    .o_hi(hi));
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic meas();
    @(posedge clk);
    clr <= 1'b0;
    repeat (64) @(posedge clk);
    clr <= 1'b1;
    #1;
  endtask
  task automatic stop_test();
    $display("TB: compares=%0d errors=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    #1 `CHK(pwm, 8'hff)
    foreach (ra[k]) begin
      rd8(ra[k], v);
      `CHK(v, re[k])
    end
    rd8(8'hfd, v);
    `CHK(v, 8'h00)
    wr8(8'hfa, 8'hff);
    rd8(8'hfa, v);
    `CHK(v, 8'hfd)
    wr8(8'hfa, 8'h02);
    rd8(8'hf9, v);
    `CHK(v, 8'h00)
    wr8(8'hf9, 8'h55);
    rd8(8'hf9, v);
    `CHK(v, 8'h00)
    foreach (sv[k]) begin
      wr8(8'hfa, {sv[k], 4'h3});
      rd8(8'hf9, c0);
      `CHK(c0, 8'h00)
      // Read lands in the same clock as the fifth tick after the clear
      repeat (10 * (sv[k] + 1) - 4) @(posedge clk);
      rd8(8'hf9, v);
      `CHK(v, 8'h04)
    end
    wr8(8'hfa, 8'h00);
    rd8(8'hf9, c0);
    repeat (20) @(posedge clk);
    rd8(8'hf9, v);
    `CHK(v, c0)
    wr8(8'hf8, 8'h07);
    wr8(8'hf0, 8'h02);
    wr8(8'hf1, 8'h07);
    wr8(8'hfc, 8'h03);
    wr8(8'hfa, 8'h03);
    repeat (20) @(posedge clk);
    meas();
    `CHK(hi[0], 8'd40)
    `CHK(hi[1], 8'd0)
    `CHK(hi[7], 8'd64)
    wr8(8'hfb, 8'h01);
    meas();
    `CHK(hi[0], 8'd24)
    wr8(8'hfa, 8'h02);
    repeat (6) @(posedge clk);
    #1 `CHK(pwm, 8'hfd)
    wr8(8'hfb, 8'hfe);
    rd8(8'hfb, v);
    `CHK(v, 8'hfe)
    stop_test();
  end
endmodule
`default_nettype wire
